// ### verilog/stm_pkg.sv
// Constants and types for the system map control register bank
package stm_pkg;
  localparam int unsigned ADDR_W = 24;
  localparam logic [7:0] OFF_STC = 8'h00;
  localparam logic [7:0] OFF_SYS3 = 8'h04;
  localparam logic [7:0] OFF_BANK = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam int unsigned STC_SRC_LSB = 0;
  localparam int unsigned STC_BUF_BIT = 2;
  localparam int unsigned STC_FLASH_BIT = 3;
  localparam int unsigned STC_TWI_BIT = 4;
  localparam int unsigned SYS3_MAP_BIT = 5;
  localparam int unsigned SYS3_VEC_BIT = 6;
  localparam int unsigned BANK_KWU_BIT = 0;
  localparam logic [7:0] STC_RST = 8'h00;
  localparam logic [7:0] SYS3_RST = 8'h00;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [1:0] MODE_TWO = 2'h2;
  localparam int unsigned RD_WAIT = 1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [23:0] PWR_LO = 24'hFF_FF80;
  localparam logic [23:0] PWR_HI = 24'hFF_FF87;
  localparam logic [23:0] FLS_LO = 24'hFF_FEA8;
  localparam logic [23:0] FLS_HI = 24'hFF_FEAE;
  localparam logic [23:0] SH1A_LO = 24'hFF_FF88;
  localparam logic [23:0] SH1A_HI = 24'hFF_FF89;
  localparam logic [23:0] SH1B_LO = 24'hFF_FF8E;
  localparam logic [23:0] SH1B_HI = 24'hFF_FF8F;
  localparam logic [23:0] SH2A_LO = 24'hFF_FFA0;
  localparam logic [23:0] SH2A_HI = 24'hFF_FFA1;
  localparam logic [23:0] SH2B_LO = 24'hFF_FFA6;
  localparam logic [23:0] SH2B_HI = 24'hFF_FFA7;
  localparam logic [23:0] SH3A_LO = 24'hFF_FFD8;
  localparam logic [23:0] SH3A_HI = 24'hFF_FFD9;
  localparam logic [23:0] SH3B_LO = 24'hFF_FFDE;
  localparam logic [23:0] SH3B_HI = 24'hFF_FFDF;
  localparam logic [23:0] KBA_LO = 24'hFF_FFF0;
  localparam logic [23:0] KBA_HI = 24'hFF_FFF7;
  localparam logic [23:0] KBB_LO = 24'hFF_FFFC;
  localparam logic [23:0] KBB_HI = 24'hFF_FFFF;
  localparam logic [23:0] EXT_TWI_LO = 24'hFF_FE80;
  localparam logic [23:0] EXT_TWI_HI = 24'hFF_FE97;
  localparam logic [23:0] EXT_KBD_LO = 24'hFF_FEB0;
  localparam logic [23:0] EXT_KBD_HI = 24'hFF_FEBF;
  typedef enum logic [3:0] {
    GRP_NONE, GRP_RESERVED, GRP_PWR_PERIPH, GRP_FLASH, GRP_SCI1, GRP_IIC1,
    GRP_SCI2, GRP_PWMX, GRP_IIC0, GRP_KBD
  } stm_grp_t;
endpackage

// ### verilog/stm_reg_if.sv
// Register access strobes between bus front end and register bank
`timescale 1ns/100ps
`default_nettype none
interface stm_reg_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport front (output wr_en, output rd_en, output addr, output wdata, input rdata);
  modport regs (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### verilog/stm_ahb_front.sv
// AHB-Lite slave front end: address capture, one read wait state
`timescale 1ns/100ps
`default_nettype none
module stm_ahb_front
  import stm_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic hreadyout,
  output var logic [31:0] hrdata,
  output var logic hresp,
  stm_reg_if.front rb
);
  logic acc;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;

  // Only word transfers are used; hsize is checked only to reject the value 7
  assign acc = hsel && hready && htrans[1] && (hsize != 3'h7);
  assign rb.wr_en = wr_pend_q;
  assign rb.rd_en = rd_pend_q;
  assign rb.addr = addr_q;
  assign rb.wdata = hwdata;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= acc && hwrite;
      rd_pend_q <= acc && !hwrite;
      if (acc) begin
        addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  // Read data is registered so hrdata comes straight from a flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (acc && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_q) begin
        hreadyout <= 1'b1;
        hrdata <= rb.rdata;
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/stm_win_dec.sv
// Shared address window decoder for the register groups
`timescale 1ns/100ps
`default_nettype none
module stm_win_dec
  import stm_pkg::*;
(
  input wire logic [23:0] addr,
  input wire logic flash_en,
  input wire logic reloc,
  input wire logic twi_bank,
  input wire logic kwu_bank,
  output var stm_grp_t grp
);
  function automatic logic in_win(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  logic twi_on;
  logic kb_on;

  assign twi_on = !reloc && twi_bank;
  assign kb_on = reloc || kwu_bank;

  always_comb begin
    grp = GRP_NONE;
    if (in_win(addr, PWR_LO, PWR_HI)) begin
      grp = flash_en ? GRP_RESERVED : GRP_PWR_PERIPH;
    end else if (in_win(addr, FLS_LO, FLS_HI)) begin
      grp = flash_en ? GRP_FLASH : GRP_RESERVED;
    end else if (in_win(addr, SH1A_LO, SH1A_HI) || in_win(addr, SH1B_LO, SH1B_HI)) begin
      grp = twi_on ? GRP_IIC1 : GRP_SCI1;
    end else if (in_win(addr, SH2A_LO, SH2A_HI) || in_win(addr, SH2B_LO, SH2B_HI)) begin
      grp = twi_on ? GRP_PWMX : GRP_SCI2;
    end else if (in_win(addr, SH3A_LO, SH3A_HI) || in_win(addr, SH3B_LO, SH3B_HI)) begin
      grp = twi_on ? GRP_IIC0 : GRP_RESERVED;
    end else if (in_win(addr, KBA_LO, KBA_HI) || in_win(addr, KBB_LO, KBB_HI)) begin
      grp = kb_on ? GRP_KBD : GRP_NONE;
    end else if (reloc && in_win(addr, EXT_TWI_LO, EXT_TWI_HI)) begin
      // Own fixed addresses in extended map, 8 bytes per group
      case (addr[4:3])
        2'h0: grp = GRP_IIC1;
        2'h1: grp = GRP_PWMX;
        default: grp = GRP_IIC0;
      endcase
    end else if (reloc && in_win(addr, EXT_KBD_LO, EXT_KBD_HI)) begin
      grp = GRP_KBD;
    end
  end
endmodule
`default_nettype wire

// ### verilog/stm_sys_map_ctrl.sv
// System map control register bank with window decode and pin control
`timescale 1ns/100ps
`default_nettype none
module stm_sys_map_ctrl
  import stm_pkg::*;
#(
  parameter int unsigned PA_W = 4
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic hreadyout,
  output var logic [31:0] hrdata,
  output var logic hresp,
  input wire logic cpu_req,
  input wire logic [23:0] cpu_addr,
  input wire logic [1:0] op_mode,
  input wire logic [2:0] timer_clock_select_field,
  input wire logic [PA_W-1:0] port_a_upper_pins_i,
  input wire logic [PA_W-1:0] pa_out_data,
  input wire logic [PA_W-1:0] pa_out_dir,
  output var logic [PA_W-1:0] port_a_upper_pins_o,
  output var logic [PA_W-1:0] port_a_upper_pins_oe,
  output var logic [4:0] timer_clk_cfg_q,
  output var logic vector_ext_mode_q,
  output var logic regmap_ext_mode_q,
  output var stm_grp_t win_grp_q,
  output var logic win_reserved_q,
  output var logic win_valid_q,
  output var logic rom_enable_q,
  output var logic full_space_q
);
  if (PA_W != 4) begin : g_pa_w_check
    $error("PA_W must be 4: the buffer select covers four pins");
  end

  stm_reg_if rb ();

  logic [7:0] stc_q;
  logic [7:0] sys3_q;
  logic [7:0] bank_q;
  logic [1:0] op_mode_q;
  logic [31:0] rdata_d;
  stm_grp_t grp_d;
  logic flash_en;
  logic bus_buf;
  logic [1:0] tmr_src;
  logic reloc;

  stm_ahb_front u_front (
    .core_clk(core_clk),
    .resetn(resetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .rb(rb.front)
  );

  assign flash_en = stc_q[STC_FLASH_BIT];
  assign bus_buf = stc_q[STC_BUF_BIT];
  assign tmr_src = stc_q[STC_SRC_LSB +: 2];
  assign reloc = sys3_q[SYS3_MAP_BIT];

  stm_win_dec u_dec (
    .addr(cpu_addr),
    .flash_en(flash_en),
    .reloc(reloc),
    .twi_bank(stc_q[STC_TWI_BIT]),
    .kwu_bank(bank_q[BANK_KWU_BIT]),
    .grp(grp_d)
  );

  // Serial/timer control: all eight bits stored, low five steer this block
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stc_q <= STC_RST;
    end else if (rb.wr_en && rb.addr == OFF_STC) begin
      stc_q <= rb.wdata[7:0];
    end
  end

  // System control three; reserved bits are plain storage
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sys3_q <= SYS3_RST;
    end else if (rb.wr_en && rb.addr == OFF_SYS3) begin
      sys3_q <= rb.wdata[7:0];
    end
  end

  // Keyboard-wakeup bank switch lives here as it is not held elsewhere
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bank_q <= BANK_RST;
    end else if (rb.wr_en && rb.addr == OFF_BANK) begin
      bank_q <= {7'h00, rb.wdata[BANK_KWU_BIT]};
    end
  end

  // Readback; unmapped words read as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (rb.addr)
      OFF_STC: rdata_d[7:0] = stc_q;
      OFF_SYS3: rdata_d[7:0] = sys3_q;
      OFF_BANK: rdata_d[7:0] = bank_q;
      OFF_STAT: rdata_d[7:0] = {port_a_upper_pins_i, op_mode_q, full_space_q, rom_enable_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end
  assign rb.rdata = rdata_d;

  // Mode pins taken after reset release, never inside the reset branch
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      op_mode_q <= 2'h0;
      rom_enable_q <= 1'b0;
      full_space_q <= 1'b0;
    end else begin
      op_mode_q <= op_mode;
      rom_enable_q <= (op_mode_q == MODE_TWO);
      full_space_q <= (op_mode_q == MODE_TWO);
    end
  end

  // Mode outputs follow the register; a change mid-interrupt is software's hazard
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vector_ext_mode_q <= 1'b0;
      regmap_ext_mode_q <= 1'b0;
    end else begin
      vector_ext_mode_q <= sys3_q[SYS3_VEC_BIT];
      regmap_ext_mode_q <= sys3_q[SYS3_MAP_BIT];
    end
  end

  // Timer source: tmr_src bits on top, clock-select field below
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      timer_clk_cfg_q <= 5'h00;
    end else begin
      timer_clk_cfg_q <= {tmr_src, timer_clock_select_field};
    end
  end

  // Bus-driving mode drives low only, so several devices can share the wire
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      port_a_upper_pins_o <= '0;
      port_a_upper_pins_oe <= '0;
    end else if (bus_buf) begin
      port_a_upper_pins_o <= '0;
      port_a_upper_pins_oe <= pa_out_dir & ~pa_out_data;
    end else begin
      port_a_upper_pins_o <= pa_out_data;
      port_a_upper_pins_oe <= pa_out_dir;
    end
  end

  // Window decode registered: one cycle from cpu_addr to group
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      win_grp_q <= GRP_NONE;
      win_reserved_q <= 1'b0;
      win_valid_q <= 1'b0;
    end else begin
      win_grp_q <= cpu_req ? grp_d : GRP_NONE;
      win_reserved_q <= cpu_req && (grp_d == GRP_RESERVED);
      win_valid_q <= cpu_req && (grp_d != GRP_RESERVED) && (grp_d != GRP_NONE);
    end
  end

  AST_PWR_WINDOW: assert property (@(posedge core_clk) disable iff (!resetn)
    cpu_req && !flash_en && cpu_addr >= PWR_LO && cpu_addr <= PWR_HI
    |=> win_grp_q == GRP_PWR_PERIPH && win_valid_q)
    else $error("power-down window not decoded with flash window off");

  AST_FLASH_WINDOW: assert property (@(posedge core_clk) disable iff (!resetn)
    cpu_req && flash_en && cpu_addr >= FLS_LO && cpu_addr <= FLS_HI
    |=> win_grp_q == GRP_FLASH)
    else $error("flash window not decoded with flash window on");

  AST_STC_WRITE: assert property (@(posedge core_clk) disable iff (!resetn)
    rb.wr_en && rb.addr == OFF_STC
    |=> flash_en == $past(rb.wdata[STC_FLASH_BIT]) ##1 rdata_d[STC_FLASH_BIT] == flash_en
        || rb.addr != OFF_STC)
    else $error("window enable bit did not take written value");

  AST_PIN_BUFFER: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_buf && $stable(bus_buf)
    |=> port_a_upper_pins_o == '0 && port_a_upper_pins_oe == ($past(pa_out_dir) & ~$past(pa_out_data)))
    else $error("port A bus-drive pins drive high or wrong enable");

  AST_TIMER_SRC: assert property (@(posedge core_clk) disable iff (!resetn)
    1'b1 |=> timer_clk_cfg_q[4:3] == $past(tmr_src) && timer_clk_cfg_q[2:0] == $past(timer_clock_select_field))
    else $error("timer source config does not follow select bits");

  AST_VECTOR_MODE: assert property (@(posedge core_clk) disable iff (!resetn)
    rb.wr_en && rb.addr == OFF_SYS3
    |=> ##1 vector_ext_mode_q == $past(rb.wdata[SYS3_VEC_BIT], 2))
    else $error("vector table mode not taken two cycles after write");

  AST_MAP_IGNORES_BANK: assert property (@(posedge core_clk) disable iff (!resetn)
    cpu_req && reloc && cpu_addr >= SH1A_LO && cpu_addr <= SH1A_HI
    |=> win_grp_q == GRP_SCI1)
    else $error("extended map still follows the two-wire bank bit");

  AST_EXT_OWN_ADDR: assert property (@(posedge core_clk) disable iff (!resetn)
    cpu_req && reloc && cpu_addr >= EXT_KBD_LO && cpu_addr <= EXT_KBD_HI
    |=> win_grp_q == GRP_KBD && win_valid_q)
    else $error("relocated keyboard group not reachable in extended map");

  AST_SYS3_STORE: assert property (@(posedge core_clk) disable iff (!resetn)
    rb.wr_en && rb.addr == OFF_SYS3 |=> sys3_q == $past(rb.wdata[7:0]))
    else $error("system control three did not store written byte");

  AST_MODE_TWO: assert property (@(posedge core_clk) disable iff (!resetn)
    op_mode_q == MODE_TWO |=> rom_enable_q && full_space_q)
    else $error("mode 2 without ROM or full address space");

  AST_RESERVED_NONE: assert property (@(posedge core_clk) disable iff (!resetn)
    cpu_req && flash_en && cpu_addr >= PWR_LO && cpu_addr <= PWR_HI
    |=> win_reserved_q && !win_valid_q && win_grp_q == GRP_RESERVED)
    else $error("reserved window selected a register group");

  // Window, register, pin and mode checks; stores change only on a write to their own word
  AST_FLASH_RESERVED: assert property (@(posedge core_clk) disable iff (!resetn)
    cpu_req && !flash_en && cpu_addr >= FLS_LO && cpu_addr <= FLS_HI
    |=> win_reserved_q && !win_valid_q && win_grp_q == GRP_RESERVED)
    else $error("flash window not reserved with flash window off");

  AST_FLASH_VALID: assert property (@(posedge core_clk) disable iff (!resetn)
    cpu_req && flash_en && cpu_addr >= FLS_LO && cpu_addr <= FLS_HI
    |=> win_valid_q && !win_reserved_q)
    else $error("flash window not flagged as a valid group");

  AST_WIN_ENABLE_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    !(rb.wr_en && rb.addr == OFF_STC)
    |=> $stable(flash_en))
    else $error("window enable bit changed without a write");

  AST_STC_READ: assert property (@(posedge core_clk) disable iff (!resetn)
    rb.rd_en && rb.addr == OFF_STC
    |=> hrdata == {24'h00_0000, $past(stc_q)})
    else $error("serial/timer control readback wrong");

  AST_BUF_WRITE: assert property (@(posedge core_clk) disable iff (!resetn)
    rb.wr_en && rb.addr == OFF_STC
    |=> bus_buf == $past(rb.wdata[STC_BUF_BIT]))
    else $error("bus-buffer select did not take written value");

  AST_PIN_NORMAL: assert property (@(posedge core_clk) disable iff (!resetn)
    !bus_buf
    |=> port_a_upper_pins_o == $past(pa_out_data) && port_a_upper_pins_oe == $past(pa_out_dir))
    else $error("port A pins not normal with bus-buffer select off");

  AST_SRC_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    !(rb.wr_en && rb.addr == OFF_STC)
    |=> $stable(tmr_src))
    else $error("timer source bits changed without a write");

  AST_VECTOR_FOLLOW: assert property (@(posedge core_clk) disable iff (!resetn)
    1'b1
    |=> vector_ext_mode_q == $past(sys3_q[SYS3_VEC_BIT]))
    else $error("vector table mode does not follow its register bit");

  AST_MAP_FOLLOW: assert property (@(posedge core_clk) disable iff (!resetn)
    1'b1
    |=> regmap_ext_mode_q == $past(reloc))
    else $error("register map mode does not follow its register bit");

  AST_MAP_WRITE: assert property (@(posedge core_clk) disable iff (!resetn)
    rb.wr_en && rb.addr == OFF_SYS3
    |=> ##1 regmap_ext_mode_q == $past(rb.wdata[SYS3_MAP_BIT], 2))
    else $error("register map mode not taken two cycles after write");

  AST_EXT_TWO_WIRE: assert property (@(posedge core_clk) disable iff (!resetn)
    cpu_req && reloc && cpu_addr >= EXT_TWI_LO && cpu_addr <= EXT_TWI_HI
    |=> win_valid_q && win_grp_q inside {GRP_IIC1, GRP_PWMX, GRP_IIC0})
    else $error("relocated two-wire groups not reachable in extended map");

  AST_EXT_HIDDEN: assert property (@(posedge core_clk) disable iff (!resetn)
    cpu_req && !reloc && cpu_addr >= EXT_TWI_LO && cpu_addr <= EXT_TWI_HI
    |=> win_grp_q == GRP_NONE && !win_valid_q)
    else $error("relocated addresses decoded in compatible map");

  AST_SYS3_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    !(rb.wr_en && rb.addr == OFF_SYS3)
    |=> $stable(sys3_q))
    else $error("system control three changed without a write");

  AST_SYS3_READ: assert property (@(posedge core_clk) disable iff (!resetn)
    rb.rd_en && rb.addr == OFF_SYS3
    |=> hrdata == {24'h00_0000, $past(sys3_q)})
    else $error("system control three readback wrong");

  AST_NOT_MODE_TWO: assert property (@(posedge core_clk) disable iff (!resetn)
    op_mode_q != MODE_TWO
    |=> !rom_enable_q && !full_space_q)
    else $error("ROM or full space flagged outside mode 2");

  AST_TWI_BANK_COMPAT: assert property (@(posedge core_clk) disable iff (!resetn)
    cpu_req && !reloc && stc_q[STC_TWI_BIT] && cpu_addr >= SH1A_LO && cpu_addr <= SH1A_HI
    |=> win_grp_q == GRP_IIC1)
    else $error("compatible map ignores the two-wire bank bit");

  AST_KBD_EXT: assert property (@(posedge core_clk) disable iff (!resetn)
    cpu_req && reloc && cpu_addr >= KBA_LO && cpu_addr <= KBA_HI
    |=> win_grp_q == GRP_KBD)
    else $error("extended map still follows the keyboard bank bit");

  AST_SH2_EXT: assert property (@(posedge core_clk) disable iff (!resetn)
    cpu_req && reloc && cpu_addr >= SH2A_LO && cpu_addr <= SH2A_HI
    |=> win_grp_q == GRP_SCI2)
    else $error("extended map switched the second shared window");

  AST_SH3_EXT: assert property (@(posedge core_clk) disable iff (!resetn)
    cpu_req && reloc && cpu_addr >= SH3A_LO && cpu_addr <= SH3A_HI
    |=> win_reserved_q && !win_valid_q)
    else $error("third shared window not reserved in extended map");

  AST_NO_REQ: assert property (@(posedge core_clk) disable iff (!resetn)
    !cpu_req
    |=> win_grp_q == GRP_NONE && !win_valid_q && !win_reserved_q)
    else $error("window outputs active without a request");
endmodule
`default_nettype wire

// ### verif/stm_cpu_model.sv
// CPU core model: AHB-Lite master issuing single word transfers
`timescale 1ns/100ps
`default_nettype none
module stm_cpu_model
  import stm_pkg::*;
(
  input wire logic core_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output var logic hsel,
  output var logic [31:0] haddr,
  output var logic [1:0] htrans,
  output var logic hwrite,
  output var logic [2:0] hsize,
  output var logic [31:0] hwdata,
  output var logic irq_enabled
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    irq_enabled = 1'b1;
  end

  // Called right after a rising edge; returns at the edge that ends the data phase
  task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd, output bit ok);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    rd = hrdata;
    ok = (hready === 1'b1);
    // Released data lines show garbage, not the last value
    hwdata <= ~wd;
  endtask

  // Interrupts off for the mode write only; they are back on before the mode bits change; reserved bits always written 0
  task automatic set_modes(input logic [31:0] d, output bit ok);
    logic [31:0] r;
    irq_enabled = 1'b0;
    xfer({24'h00_0000, OFF_SYS3}, 1'b1, d & 32'h0000_0060, r, ok);
    irq_enabled = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the system map control register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import stm_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic cpu_req = 1'b0;
  logic [23:0] cpu_addr = 24'h00_0000;
  logic [1:0] op_mode = 2'h2;
  logic [2:0] tcs = 3'h5;
  logic [3:0] pa_in = 4'h9;
  logic [3:0] pa_dat = 4'h5;
  logic [3:0] pa_dir = 4'hF;
  logic hsel, hwrite, hreadyout, hresp, irq_en;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] pa_o, pa_oe;
  logic [4:0] tcfg;
  logic vec_m, map_m, rsv, vld, rom_en, full_sp;
  stm_grp_t grp;
  int num_errors = 0;
  int check_count = 0;

  always #20 core_clk = ~core_clk;

  stm_sys_map_ctrl dut (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
    .op_mode(op_mode), .timer_clock_select_field(tcs), .port_a_upper_pins_i(pa_in),
    .pa_out_data(pa_dat), .pa_out_dir(pa_dir), .port_a_upper_pins_o(pa_o),
    .port_a_upper_pins_oe(pa_oe), .timer_clk_cfg_q(tcfg), .vector_ext_mode_q(vec_m),
    .regmap_ext_mode_q(map_m), .win_grp_q(grp), .win_reserved_q(rsv), .win_valid_q(vld),
    .rom_enable_q(rom_en), .full_space_q(full_sp));

  stm_cpu_model cpu (.core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .irq_enabled(irq_en));

  task automatic summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    bit ok;
    cpu.xfer(a, w, d, r, ok);
    if (!ok) begin
      num_errors++;
      summarize();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0000_0000, r);
    chk(name, r, exp);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  // Decoded group lands one edge after the address is presented
  task automatic win(input logic [23:0] a, input stm_grp_t g);
    cpu_req <= 1'b1;
    cpu_addr <= a;
    @(posedge core_clk);
    #1;
    chk("win_grp", {28'h000_0000, grp}, {28'h000_0000, g});
    chk("win_reserved", {31'h0, rsv}, {31'h0, g == GRP_RESERVED});
    chk("win_valid", {31'h0, vld}, {31'h0, !(g inside {GRP_NONE, GRP_RESERVED})});
    @(posedge core_clk);
  endtask

  initial begin
    bit ok;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rchk("stc_reset", 32'h0, 32'h0000_0000);
    rchk("sys3_reset", 32'h4, 32'h0000_0000);
    rchk("status", 32'hC, 32'h0000_009B);
    chk("rom_en", {31'h0, rom_en}, 32'h1);
    chk("full_space", {31'h0, full_sp}, 32'h1);
    chk("pa_o_normal", {28'h0, pa_o}, 32'h5);
    chk("pa_oe_normal", {28'h0, pa_oe}, 32'hF);
    win(PWR_LO, GRP_PWR_PERIPH);
    win(PWR_HI, GRP_PWR_PERIPH);
    win(FLS_LO, GRP_RESERVED);
    win(FLS_HI, GRP_RESERVED);
    win(SH1A_LO, GRP_SCI1);
    win(SH2B_HI, GRP_SCI2);
    win(SH3A_LO, GRP_RESERVED);
    win(KBA_LO, GRP_NONE);
    win(EXT_TWI_LO, GRP_NONE);
    win(EXT_KBD_LO, GRP_NONE);
    wr(32'h0, 32'h0000_001F);
    @(posedge core_clk);
    #1;
    chk("timer_cfg", {27'h0, tcfg}, 32'h0000_001D);
    chk("pa_o_bus", {28'h0, pa_o}, 32'h0);
    chk("pa_oe_bus", {28'h0, pa_oe}, 32'hA);
    @(posedge core_clk);
    rchk("stc_rw", 32'h0, 32'h0000_001F);
    win(FLS_LO, GRP_FLASH);
    win(FLS_HI, GRP_FLASH);
    win(PWR_LO, GRP_RESERVED);
    win(PWR_HI, GRP_RESERVED);
    win(SH1A_HI, GRP_IIC1);
    win(SH2A_LO, GRP_PWMX);
    win(SH3B_LO, GRP_IIC0);
    wr(32'h8, 32'h0000_0001);
    win(KBB_LO, GRP_KBD);
    cpu.set_modes(32'h0000_0060, ok);
    chk("modes_ok", {31'h0, ok}, 32'h1);
    chk("irq_restored", {31'h0, irq_en}, 32'h1);
    rchk("sys3_rw", 32'h4, 32'h0000_0060);
    chk("vec_mode", {31'h0, vec_m}, 32'h1);
    chk("map_mode", {31'h0, map_m}, 32'h1);
    win(SH1A_LO, GRP_SCI1);
    win(SH2A_LO, GRP_SCI2);
    win(SH3A_LO, GRP_RESERVED);
    win(EXT_TWI_LO, GRP_IIC1);
    win(24'hFF_FE88, GRP_PWMX);
    win(EXT_TWI_HI, GRP_IIC0);
    win(EXT_KBD_LO, GRP_KBD);
    wr(32'h8, 32'h0000_0000);
    win(KBA_LO, GRP_KBD);
    cpu.set_modes(32'h0000_0040, ok);
    chk("modes_ok", {31'h0, ok}, 32'h1);
    @(posedge core_clk);
    #1;
    chk("map_compat", {31'h0, map_m}, 32'h0);
    chk("vec_keep", {31'h0, vec_m}, 32'h1);
    win(SH1A_LO, GRP_IIC1);
    wr(32'h10, 32'h0000_00FF);
    rchk("unmapped", 32'h10, 32'h0000_0000);
    rchk("stc_keep", 32'h0, 32'h0000_001F);
    op_mode <= 2'h1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("rom_off", {31'h0, rom_en}, 32'h0);
    chk("full_off", {31'h0, full_sp}, 32'h0);
    @(posedge core_clk);
    summarize();
  end
endmodule
`default_nettype wire
